// ===== hw/lnsf_pkg.sv
// Package for the LAN node status flag block: register offsets, bit positions, command codes.
// Assumes a single 200 MHz clock domain and an I/O-mapped host port of 4 address bits.
package lnsf_pkg;
   // ----------------------------------------------------------------
   // Register offsets within the 16-location I/O block.
   // ----------------------------------------------------------------
   localparam logic [3:0] OFS_STATUS = 4'h0; // Read: node_status. Write: interrupt mask.
   localparam logic [3:0] OFS_DIAG = 4'h1; // Read: diag_flags. Write: command.
   localparam logic [3:0] OFS_NODE_ID = 4'h5;
   localparam logic [3:0] OFS_SOFT_RST = 4'h8;
   // ----------------------------------------------------------------
   // Status and diagnostic bit positions.
   // ----------------------------------------------------------------
   localparam int BIT_RI = 7;
   localparam int BIT_POR = 4;
   localparam int BIT_TEST = 3;
   localparam int BIT_RECONFIG_FLAG = 2;
   localparam int BIT_TMA = 1;
   localparam int BIT_TA = 0;
   localparam int BIT_SELF = 7;
   localparam int BIT_ACT = 5;
   localparam int BIT_TOK = 4;
   // ----------------------------------------------------------------
   // Reset values; undefined bits are driven as zero.
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_STATUS = 8'h91;
   localparam logic [7:0] RST_DIAG = 8'h00;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_NODE_ID = 8'h00;
   // ----------------------------------------------------------------
   // Command encodings: the two disable commands match the whole byte; the others are selected by the low three bits.
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_TX_DISABLE = 8'h01;
   localparam logic [7:0] CMD_RX_DISABLE = 8'h02;
   localparam logic [2:0] CMD_TX_ENABLE = 3'h3;
   localparam logic [2:0] CMD_RX_ENABLE = 3'h4;
   localparam logic [2:0] CMD_CLR_FLAGS = 3'h6;
   localparam int CMD_CLR_POR_BIT = 3;
   localparam int CMD_CLR_RECONFIG_FLAG_BIT = 4;
   localparam int CMD_RX_BCAST_BIT = 7;
   // ----------------------------------------------------------------
   // Line idle time before reconfiguration, and its clock count.
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int IDLE_US = 82;
   localparam int IDLE_CYCLES = IDLE_US * CLK_MHZ;
endpackage

// ===== hw/lnsf_sync.sv
// Two flip-flop synchroniser for a level from outside the clock domain.
// Assumes the input is a plain level; a pulse shorter than one clock may be lost.
`timescale 1ns/1ps
`default_nettype none
module lnsf_sync (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic async_in,
   output logic sync_out
);
   logic stage1;
   logic next_stage1;
   logic next_sync_out;

   // The first stage is read only by the second stage.
   always_comb begin
      next_stage1 = async_in;
      next_sync_out = stage1;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stage1 <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         stage1 <= next_stage1;
         sync_out <= next_sync_out;
      end
   end
endmodule // lnsf_sync
`default_nettype wire

// ===== hw/lnsf_flags.sv
// Status, diagnostic-status and interrupt logic of a token-passing LAN node.
// Assumes a host I/O port synchronous to clk and protocol-engine event pulses on clk.
`timescale 1ns/1ps
`default_nettype none
module lnsf_flags
   import lnsf_pkg::*;
#(
   parameter int IDLE_COUNT = IDLE_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] ioAddr,
   input wire logic ioWrite,
   input wire logic ioRead,
   input wire logic [7:0] ioWdata,
   output logic [7:0] ioRdata,
   input wire logic line_rx_input,
   input wire logic tokenToUs,
   input wire logic pktStored,
   input wire logic txDone,
   input wire logic txAckReceived,
   input wire logic txWasBroadcast,
   input wire logic tokenRxTimeout,
   input wire logic foreignToken,
   output logic host_irq,
   output logic rxAccept,
   output logic [1:0] rxPage,
   output logic rxBroadcast,
   output logic txRequest,
   output logic [1:0] txPage
);
   // ----------------------------------------------------------------
   // Parameter check.
   // ----------------------------------------------------------------
   if (IDLE_COUNT < 2 || IDLE_COUNT > 65535) begin : g_bad_idle
      $error("IDLE_COUNT out of range");
   end

   // ----------------------------------------------------------------
   // Line input synchroniser and edge detector.
   // ----------------------------------------------------------------
   logic rxSync;
   logic rxPrev;
   logic rxEdge;
   lnsf_sync u_rx_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in(line_rx_input),
      .sync_out(rxSync)
   );
   assign rxEdge = rxSync ^ rxPrev;

   // ----------------------------------------------------------------
   // Host access decode; writes and reads are one-cycle strobes.
   // ----------------------------------------------------------------
   logic cmdWr, maskWr, nodeWr, softRst, diagRd, anyRst;
   logic [2:0] cmdCode;
   always_comb begin
      cmdWr = 1'b0;
      maskWr = 1'b0;
      nodeWr = 1'b0;
      softRst = 1'b0;
      if (ioWrite && ioAddr == OFS_STATUS) begin
         maskWr = 1'b1;
      end else if (ioWrite && ioAddr == OFS_DIAG) begin
         cmdWr = 1'b1;
      end else if (ioWrite && ioAddr == OFS_NODE_ID) begin
         nodeWr = 1'b1;
      end else if (ioWrite && ioAddr[3:2] == OFS_SOFT_RST[3:2]) begin
         softRst = 1'b1;
      end
   end
   assign diagRd = ioRead && ioAddr == OFS_DIAG;
   assign cmdCode = ioWdata[2:0];
   assign anyRst = sys_rst || softRst;

   // ----------------------------------------------------------------
   // Flag state.
   // ----------------------------------------------------------------
   logic ri, por, reconfig_flag, tx_acked, ta, selfRecon, rxAct, tokSeen;
   logic [7:0] mask, nodeId;
   logic txPend, txDisPend;
   logic [15:0] idleCnt;
   logic next_ri, next_por, next_reconfig_flag, next_tma, next_ta;
   logic next_selfRecon, next_rxAct, next_tokSeen;
   logic [7:0] next_mask, next_nodeId;
   logic next_txPend, next_txDisPend;
   logic [15:0] next_idleCnt;
   logic next_rxAccept, next_rxBroadcast, next_txRequest;
   logic [1:0] next_rxPage, next_txPage;
   logic [7:0] next_ioRdata;
   logic idleExpire;

   // Idle timer restarts on every line transition; expiry is one pulse.
   assign idleExpire = (idleCnt == 16'(IDLE_COUNT - 1));

   // Events always win over clears that land in the same cycle.
   always_comb begin
      next_ri = ri;
      next_por = por;
      next_reconfig_flag = reconfig_flag;
      next_tma = tx_acked;
      next_ta = ta;
      next_selfRecon = selfRecon;
      next_rxAct = rxAct;
      next_tokSeen = tokSeen;
      next_mask = mask;
      next_nodeId = nodeId;
      next_txPend = txPend;
      next_txDisPend = txDisPend;
      next_rxAccept = rxAccept;
      next_rxPage = rxPage;
      next_rxBroadcast = rxBroadcast;
      next_txRequest = txRequest;
      next_txPage = txPage;
      next_idleCnt = rxEdge ? 16'h0000 : (idleExpire ? 16'h0000 : idleCnt + 16'h0001);
      if (maskWr) begin
         next_mask = ioWdata;
      end
      if (nodeWr) begin
         next_nodeId = ioWdata;
         if (ioWdata == 8'h00) begin
            next_por = 1'b1;
         end
      end
      // Diagnostic flags clear on read, set again by a coincident event.
      if (diagRd) begin
         next_selfRecon = 1'b0;
         next_rxAct = 1'b0;
         next_tokSeen = 1'b0;
      end
      if (cmdWr) begin
         if (ioWdata == CMD_TX_DISABLE) begin
            next_txDisPend = 1'b1;
            next_txPend = 1'b0;
         end else if (ioWdata == CMD_RX_DISABLE) begin
            next_rxAccept = 1'b0;
         end else if (cmdCode == CMD_TX_ENABLE) begin
            next_tma = 1'b0;
            next_ta = 1'b0;
            next_txPend = 1'b1;
            next_txPage = ioWdata[4:3];
         end else if (cmdCode == CMD_RX_ENABLE) begin
            next_ri = 1'b0;
            next_rxAccept = 1'b1;
            next_rxPage = ioWdata[4:3];
            next_rxBroadcast = ioWdata[CMD_RX_BCAST_BIT];
         end else if (cmdCode == CMD_CLR_FLAGS) begin
            if (ioWdata[CMD_CLR_POR_BIT]) begin
               next_por = 1'b0;
            end
            if (ioWdata[CMD_CLR_RECONFIG_FLAG_BIT]) begin
               next_reconfig_flag = 1'b0;
            end
         end
      end
      // Token arrival launches a pending transmit or a pending disable.
      if (tokenToUs && txPend) begin
         next_txRequest = 1'b1;
         next_txPend = 1'b0;
      end
      if (tokenToUs && txDisPend) begin
         next_ta = 1'b1;
         next_txDisPend = 1'b0;
      end
      if (txDone && txRequest) begin
         next_ta = 1'b1;
         next_txRequest = 1'b0;
      end
      if (txAckReceived && txRequest && !txWasBroadcast) begin
         next_tma = 1'b1;
      end
      if (pktStored && rxAccept) begin
         next_ri = 1'b1;
         next_rxAccept = 1'b0;
      end
      if (idleExpire) begin
         next_reconfig_flag = 1'b1;
      end
      if (tokenRxTimeout) begin
         next_selfRecon = 1'b1;
      end
      if (rxEdge) begin
         next_rxAct = 1'b1;
      end
      if (foreignToken) begin
         next_tokSeen = 1'b1;
      end
   end

   // Read data: unused bits and the test bit read zero.
   always_comb begin
      next_ioRdata = 8'h00;
      if (ioRead && ioAddr == OFS_STATUS) begin
         next_ioRdata[BIT_RI] = ri;
         next_ioRdata[BIT_POR] = por;
         next_ioRdata[BIT_TEST] = 1'b0;
         next_ioRdata[BIT_RECONFIG_FLAG] = reconfig_flag;
         next_ioRdata[BIT_TMA] = tx_acked;
         next_ioRdata[BIT_TA] = ta;
      end else if (diagRd) begin
         next_ioRdata[BIT_SELF] = selfRecon;
         next_ioRdata[BIT_ACT] = rxAct;
         next_ioRdata[BIT_TOK] = tokSeen;
      end else if (ioRead && ioAddr == OFS_NODE_ID) begin
         next_ioRdata = nodeId;
      end
   end

   // Hardware or software reset restores defaults; software reset keeps the node id.
   always_ff @(posedge clk) begin
      if (anyRst) begin
         ri <= RST_STATUS[BIT_RI];
         por <= RST_STATUS[BIT_POR];
         reconfig_flag <= RST_STATUS[BIT_RECONFIG_FLAG];
         tx_acked <= RST_STATUS[BIT_TMA];
         ta <= RST_STATUS[BIT_TA];
         selfRecon <= RST_DIAG[BIT_SELF];
         rxAct <= RST_DIAG[BIT_ACT];
         tokSeen <= RST_DIAG[BIT_TOK];
         mask <= RST_MASK;
         txPend <= 1'b0;
         txDisPend <= 1'b0;
         idleCnt <= 16'h0000;
         rxAccept <= 1'b0;
         rxPage <= 2'h0;
         rxBroadcast <= 1'b0;
         txRequest <= 1'b0;
         txPage <= 2'h0;
      end else begin
         ri <= next_ri;
         por <= next_por;
         reconfig_flag <= next_reconfig_flag;
         tx_acked <= next_tma;
         ta <= next_ta;
         selfRecon <= next_selfRecon;
         rxAct <= next_rxAct;
         tokSeen <= next_tokSeen;
         mask <= next_mask;
         txPend <= next_txPend;
         txDisPend <= next_txDisPend;
         idleCnt <= next_idleCnt;
         rxAccept <= next_rxAccept;
         rxPage <= next_rxPage;
         rxBroadcast <= next_rxBroadcast;
         txRequest <= next_txRequest;
         txPage <= next_txPage;
      end
   end

   // Node id, read data and the edge history follow only the hardware reset.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         nodeId <= RST_NODE_ID;
         ioRdata <= 8'h00;
         rxPrev <= 1'b0;
      end else begin
         nodeId <= next_nodeId;
         ioRdata <= next_ioRdata;
         rxPrev <= rxSync;
      end
   end

   // Masked ri, reconfig and ta flags form the interrupt; tx acked and por are never sources.
   assign host_irq = (ri & mask[BIT_RI]) | (reconfig_flag & mask[BIT_RECONFIG_FLAG]) | (ta & mask[BIT_TA]);

   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   sequence s_rxEnable;
      cmdWr && cmdCode == CMD_RX_ENABLE && !pktStored && !softRst;
   endsequence
   property p_diag_clear;
      @(posedge clk) disable iff (sys_rst)
      diagRd && !tokenRxTimeout && !rxEdge && !foreignToken && !softRst
         |=> !selfRecon && !rxAct && !tokSeen;
   endproperty
   a_diag_clear: assert property (p_diag_clear) else $error("diag flags not cleared");
   property p_reset_values;
      @(posedge clk) softRst |=> ri && por && ta && !reconfig_flag && !tx_acked && !selfRecon && !rxAct;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("bad reset values");
   property p_ri_set;
      @(posedge clk) disable iff (sys_rst) pktStored && rxAccept && !softRst |=> ri && !rxAccept;
   endproperty
   a_ri_set: assert property (p_ri_set) else $error("ri not set");
   property p_ri_clear;
      @(posedge clk) disable iff (sys_rst) s_rxEnable |=> !ri ##0 rxAccept;
   endproperty
   a_ri_clear: assert property (p_ri_clear) else $error("ri not cleared");
   property p_por_hold;
      @(posedge clk) disable iff (sys_rst) por && !cmdWr |=> por;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("por lost");
   property p_irq;
      @(posedge clk) disable iff (sys_rst) maskWr && ioWdata == (8'h01 << BIT_TMA) |=> !host_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");
   property p_idle_reconfig_flag;
      @(posedge clk) disable iff (sys_rst) idleExpire && !softRst |=> reconfig_flag;
   endproperty
   a_idle_reconfig_flag: assert property (p_idle_reconfig_flag) else $error("reconfig_flag not set");
   property p_tx_enable;
      @(posedge clk) disable iff (sys_rst) cmdWr && cmdCode == CMD_TX_ENABLE && !softRst
         && !tokenToUs && !txDone && !txAckReceived |=> !ta && !tx_acked;
   endproperty
   a_tx_enable: assert property (p_tx_enable) else $error("tx flags not cleared");
   property p_activity;
      @(posedge clk) disable iff (sys_rst) rxEdge && !softRst |=> rxAct;
   endproperty
   a_activity: assert property (p_activity) else $error("activity missed");
endmodule // lnsf_flags
`default_nettype wire

// ===== tb/lnsf_engine_model.sv
// Behavioural protocol engine and receive line facing the status flag block.
// Assumes the flag block's engine-side ports and one shared clock.
`timescale 1ns/1ps
`default_nettype none
module lnsf_engine_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic lineOn,
   input wire logic bcastMode,
   input wire logic pktGo,
   input wire logic rxAccept,
   input wire logic txRequest,
   output logic line_rx_input,
   output logic tokenToUs,
   output logic pktStored,
   output logic txDone,
   output logic txAckReceived,
   output logic txWasBroadcast
);
   logic [3:0] cnt;

   // ----------------------------------------------------------------
   // Token rotation, line activity, packet and transmit events
   // ----------------------------------------------------------------
   // A token arrives every 16 cycles; a transmit completes 4 cycles later.
   // The line toggles every 4 cycles so the idle timer stays quiet when on.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt <= 4'h0;
         line_rx_input <= 1'b0;
         tokenToUs <= 1'b0;
         pktStored <= 1'b0;
         txDone <= 1'b0;
         txAckReceived <= 1'b0;
         txWasBroadcast <= 1'b0;
      end else begin
         cnt <= cnt + 4'h1;
         if (lineOn && cnt[1:0] == 2'h0) begin
            line_rx_input <= !line_rx_input;
         end
         tokenToUs <= (cnt == 4'hf);
         pktStored <= rxAccept && pktGo && !pktStored;
         txDone <= txRequest && (cnt == 4'h3);
         // The ack pulses in broadcast mode too, so the block's own broadcast gate is tested.
         txAckReceived <= txRequest && (cnt == 4'h3);
         txWasBroadcast <= bcastMode;
      end
   end
endmodule // lnsf_engine_model
`default_nettype wire

// ===== tb/lnsf_flags_tb.sv
// Self-checking bench for the status flag block, driving its host I/O port.
// Assumes lnsf_pkg, lnsf_flags and the engine model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module lnsf_flags_tb;
   import lnsf_pkg::*;
   logic clk, sys_rst, ioWrite, ioRead, lineOn, bcastMode, pktGo;
   logic [3:0] ioAddr;
   logic [7:0] ioWdata, ioRdata, v;
   logic tokenRxTimeout, foreignToken, host_irq, rxAccept, rxBroadcast, txRequest;
   logic [1:0] rxPage, txPage;
   logic line_rx_input, tokenToUs, pktStored, txDone, txAckReceived, txWasBroadcast;
   int checks, miscompares, cyc;
   logic [7:0] cmd;

   lnsf_flags #(.IDLE_COUNT(20)) dut (.clk(clk), .sys_rst(sys_rst), .ioAddr(ioAddr),
      .ioWrite(ioWrite), .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata),
      .line_rx_input(line_rx_input), .tokenToUs(tokenToUs), .pktStored(pktStored),
      .txDone(txDone), .txAckReceived(txAckReceived), .txWasBroadcast(txWasBroadcast),
      .tokenRxTimeout(tokenRxTimeout), .foreignToken(foreignToken), .host_irq(host_irq),
      .rxAccept(rxAccept), .rxPage(rxPage), .rxBroadcast(rxBroadcast),
      .txRequest(txRequest), .txPage(txPage));

   lnsf_engine_model engine (.clk(clk), .sys_rst(sys_rst), .lineOn(lineOn),
      .bcastMode(bcastMode), .pktGo(pktGo), .rxAccept(rxAccept), .txRequest(txRequest),
      .line_rx_input(line_rx_input), .tokenToUs(tokenToUs), .pktStored(pktStored),
      .txDone(txDone), .txAckReceived(txAckReceived), .txWasBroadcast(txWasBroadcast));

   // ----------------------------------------------------------------
   // Clock, run limit and closing report
   // ----------------------------------------------------------------
   // Free-running 200 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = !clk;
   end

   task automatic results();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // The whole sequence needs well under 2000 cycles; a hang stops at 6000.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         miscompares++;
         results();
      end
   end

   // ----------------------------------------------------------------
   // Host I/O access tasks
   // ----------------------------------------------------------------
   // Strobes drop one edge after they rise, so back-to-back calls never collide.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      ioAddr <= a;
      ioWdata <= d;
      ioWrite <= 1'b1;
      @(posedge clk);
      ioWrite <= 1'b0;
   endtask

   task automatic rdv(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      ioAddr <= a;
      ioRead <= 1'b1;
      @(posedge clk);
      ioRead <= 1'b0;
      #1 d = ioRdata;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] ex, input string nm);
      logic [7:0] d;
      rdv(a, d);
      `CHK(nm, ex, d)
   endtask

   // The interrupt is combinational; two edges let a preceding write settle.
   task automatic irqIs(input logic ex);
      repeat (2) @(posedge clk);
      #1 `CHK("host_irq", ex, host_irq)
   endtask

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   // Only defined command codes are ever written to the command location.
   initial begin
      {sys_rst, ioWrite, ioRead, ioAddr, ioWdata} = {1'b1, 1'b0, 1'b0, 4'h0, 8'h00};
      {tokenRxTimeout, foreignToken, lineOn, bcastMode, pktGo} = 5'h00;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      rd(OFS_STATUS, 8'h91, "status after reset");
      rd(OFS_DIAG, 8'h00, "diag after reset");
      lineOn <= 1'b1;
      wr(OFS_DIAG, 8'h0e);
      rd(OFS_STATUS, 8'h81, "por cleared");
      wr(OFS_NODE_ID, 8'h05);
      rd(OFS_STATUS, 8'h81, "nonzero id");
      wr(OFS_NODE_ID, 8'h00);
      rd(OFS_STATUS, 8'h91, "zero id");
      wr(OFS_DIAG, 8'h0e);
      rd(4'h6, 8'h00, "unmapped read");
      // Diagnostic events, then a silent line long enough to expire the idle timer.
      @(posedge clk);
      {tokenRxTimeout, foreignToken} <= 2'h3;
      @(posedge clk);
      {tokenRxTimeout, foreignToken, lineOn} <= 3'h0;
      repeat (40) @(posedge clk);
      rd(OFS_DIAG, 8'hb0, "diag flags");
      rd(OFS_DIAG, 8'h00, "diag cleared by read");
      // Restart the line early so the idle timer cannot set the flag again after the clear.
      lineOn <= 1'b1;
      rd(OFS_STATUS, 8'h85, "reconfig");
      wr(OFS_STATUS, 8'h04);
      irqIs(1'b1);
      wr(OFS_DIAG, 8'h16);
      rd(OFS_STATUS, 8'h81, "reconfig cleared");
      irqIs(1'b0);
      // Mask table: ri and ta are set, tma clear.
      for (int i = 0; i < 4; i++) begin
         wr(OFS_STATUS, 8'h81 >> (i * 2) & 8'hff);
         irqIs(i < 1);
      end
      // Receive enable with and without broadcast, then a stored packet.
      for (int i = 0; i < 2; i++) begin
         cmd = i ? 8'h0c : 8'h9c;
         wr(OFS_STATUS, 8'h80);
         wr(OFS_DIAG, cmd);
         rd(OFS_STATUS, 8'h01, "ri cleared");
         `CHK("rxAccept", 1'b1, rxAccept)
         `CHK("rxPage", cmd[4:3], rxPage)
         `CHK("rxBroadcast", cmd[7], rxBroadcast)
         irqIs(1'b0);
         pktGo <= 1'b1;
         repeat (4) @(posedge clk);
         pktGo <= 1'b0;
         rd(OFS_STATUS, 8'h81, "ri set");
         `CHK("rxAccept", 1'b0, rxAccept)
         irqIs(1'b1);
      end
      // Acknowledged transmit, then a broadcast one that must not set tma.
      for (int i = 0; i < 2; i++) begin
         cmd = i ? 8'h0b : 8'h13;
         bcastMode <= i[0];
         wr(OFS_DIAG, cmd);
         rdv(OFS_STATUS, v);
         `CHK("tma cleared", 1'b0, v[1])
         for (int n = 0; n < 40 && txRequest !== 1'b1; n++) @(posedge clk);
         `CHK("txPage", cmd[4:3], txPage)
         for (int n = 0; n < 40 && txRequest !== 1'b0; n++) @(posedge clk);
         rd(OFS_STATUS, i ? 8'h81 : 8'h83, "tx done");
         wr(OFS_STATUS, 8'h02);
         irqIs(1'b0);
      end
      // Queue a transmit just after a token, then cancel it before the next one arrives.
      do begin
         @(posedge clk);
      end while (tokenToUs !== 1'b1);
      wr(OFS_DIAG, 8'h13);
      wr(OFS_DIAG, 8'h01);
      v = 8'h00;
      repeat (40) begin
         @(posedge clk);
         v[7] = v[7] | txRequest;
      end
      `CHK("transmit cancelled", 1'b0, v[7])
      rdv(OFS_STATUS, v);
      `CHK("ta after disable", 1'b1, v[0])
      // Software reset restores every flag and the mask.
      wr(OFS_STATUS, 8'h85);
      irqIs(1'b1);
      lineOn <= 1'b0;
      repeat (6) @(posedge clk);
      wr(OFS_SOFT_RST, 8'h00);
      rd(OFS_STATUS, 8'h91, "status after soft reset");
      rd(OFS_DIAG, 8'h00, "diag after soft reset");
      irqIs(1'b0);
      results();
   end
endmodule // lnsf_flags_tb
`default_nettype wire
